// ===== rtl/fcs_defs.svh
/*
  Constants for the parallel flash command sequencer: timing, unlock
  addresses, command codes, status bit positions and the register map.
  Assumes a 20 MHz ref_clk and 32-bit APB data.
*/
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ==========================================================
// timing
`define FCS_CLK_NS     50
`define FCS_T_ACC_NS   170
`define FCS_T_WP_NS    100
`define FCS_SYNC_CYC   2
`define FCS_ACC_CYC    ((`FCS_T_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WP_CYC     ((`FCS_T_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_RD_CYC     (`FCS_ACC_CYC + `FCS_SYNC_CYC)

// ==========================================================
// unlock addresses and command codes
`define FCS_U1_WORD    20'h00555
`define FCS_U2_WORD    20'h002aa
`define FCS_U1_BYTE    20'h00aaa
`define FCS_U2_BYTE    20'h00555
`define FCS_CD_AA      8'haa
`define FCS_CD_55      8'h55
`define FCS_CD_AUTO    8'h90
`define FCS_CD_PROG    8'ha0
`define FCS_CD_BYPASS  8'h20
`define FCS_CD_SETUP   8'h80
`define FCS_CD_CHIP    8'h10
`define FCS_CD_SECT    8'h30
`define FCS_CD_SUSP    8'hb0
`define FCS_CD_RESET   8'hf0
`define FCS_CD_ZERO    8'h00
`define FCS_AK_ANY     2'h0
`define FCS_AK_U1      2'h1
`define FCS_AK_U2      2'h2
`define FCS_AK_USER    2'h3

// ==========================================================
// status bits of a flash read
`define FCS_DQ_POLL    7
`define FCS_DQ_TIMEOUT 5

// ==========================================================
// register map
`define FCS_REG_CTRL   8'h00
`define FCS_REG_ADDR   8'h04
`define FCS_REG_DATA   8'h08
`define FCS_REG_CFG    8'h0c
`define FCS_REG_STAT   8'h10
`define FCS_REG_RDATA  8'h14
`define FCS_CTRL_POLL  4
`define FCS_CFG_BYTE   0
`define FCS_CFG_HWRST  1

`endif

// ===== rtl/fcs_pkg.sv
/*
  Types of the flash command sequencer.
  Assumes fcs_defs.svh supplies the numeric constants.
*/
package fcs_pkg;
  typedef enum logic [3:0] {
    CMD_READ = 4'h0, CMD_RESET = 4'h1, CMD_AUTOSEL = 4'h2,
    CMD_PROG = 4'h3, CMD_BYP_ENTER = 4'h4, CMD_BYP_PROG = 4'h5,
    CMD_BYP_EXIT = 4'h6, CMD_CHIP_ERASE = 4'h7, CMD_SECT_ERASE = 4'h8,
    CMD_SECT_ADD = 4'h9, CMD_SUSPEND = 4'ha, CMD_RESUME = 4'hb
  } fcs_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_SEQ = 3'h1, ST_POLL = 3'h2,
    ST_RECHK = 3'h3, ST_FINAL = 3'h4, ST_ABORT = 3'h5
  } fcs_state_t;
  typedef enum logic [1:0] {
    C_IDLE = 2'h0, C_SETUP = 2'h1, C_STROBE = 2'h2, C_HOLD = 2'h3
  } fcs_cyc_t;
endpackage : fcs_pkg

// ===== rtl/fcs_cycle.sv
/*
  One flash bus cycle, write or read, on the chip-select, write and
  output strobes. Assumes dq_in comes straight from the pins.
*/
`timescale 1ns/1ps
`include "fcs_defs.svh"
module fcs_cycle #(
  parameter int         AW     = 20,
  parameter int         DW     = 16,
  parameter logic [3:0] WP_CYC = 4'(`FCS_WP_CYC),
  parameter logic [3:0] RD_CYC = 4'(`FCS_RD_CYC)
) (
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  input  wire logic          start,
  input  wire logic          wr,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [DW-1:0] dq_in,
  output logic               ce_n,
  output logic               we_n,
  output logic               oe_n,
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe,
  output logic [DW-1:0]      rdata,
  output logic               done
);
  import fcs_pkg::*;
  fcs_cyc_t        state;
  logic            wr_q;
  logic [3:0]      cnt;
  logic [DW-1:0]   dq_meta;
  logic [DW-1:0]   dq_sync;

  // ==========================================================
  // pin sampling: read length covers access time plus these stages
  always_ff @(posedge ref_clk) begin
    dq_meta <= dq_in;
    dq_sync <= dq_meta;
  end

  // ==========================================================
  // strobe sequencing
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= C_IDLE;
      wr_q <= 1'h0;
      cnt <= 4'h0;
      ce_n <= 1'h1;
      we_n <= 1'h1;
      oe_n <= 1'h1;
      flash_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'h0;
      rdata <= '0;
      done <= 1'h0;
    end else begin
      unique case (state)
        C_IDLE: begin
          done <= 1'h0;
          if (start) begin
            // address and data settle before either strobe falls
            wr_q <= wr;
            flash_addr <= addr;
            dq_out <= wdata;
            dq_oe <= wr;
            ce_n <= 1'h0;
            state <= C_SETUP;
          end
        end
        C_SETUP: begin
          we_n <= !wr_q;
          oe_n <= wr_q;
          cnt <= wr_q ? WP_CYC : RD_CYC;
          state <= C_STROBE;
        end
        C_STROBE: begin
          if (cnt == 4'h1) begin
            we_n <= 1'h1;
            oe_n <= 1'h1;
            if (!wr_q) rdata <= dq_sync;
            state <= C_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        C_HOLD: begin
          // data released one clock after the write strobe rises
          ce_n <= 1'h1;
          dq_oe <= 1'h0;
          done <= 1'h1;
          state <= C_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_data_held: assert property (
    $rose(we_n) |-> dq_oe && !ce_n && $stable(dq_out) && $stable(flash_addr))
    else $error("write data or address moved at strobe rise");
  a_read_quiet: assert property (
    !oe_n |-> we_n && !dq_oe ##1 (oe_n || $stable(flash_addr)))
    else $error("read cycle drove the bus or write strobe");
endmodule : fcs_cycle

// ===== rtl/fcs_ctrl.sv
/*
  Host-side controller for a parallel NOR flash: APB registers take
  commands, the sequencer issues unlock/command cycles and polls status.
  Assumes the flash pins are wired directly and dq uses one enable.
*/
`timescale 1ns/1ps
`include "fcs_defs.svh"
module fcs_ctrl #(
  parameter int AW = 20,
  parameter int DW = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n,
  output logic               flash_reset_n,
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_dq_out,
  output logic               flash_dq_oe,
  input  wire logic [DW-1:0] flash_dq_in,
  input  wire logic          flash_ready_busy_n
);
  import fcs_pkg::*;

  fcs_state_t    state;
  fcs_state_t    next_state;
  fcs_cmd_t      cmd_q;
  logic [2:0]    step;
  logic [2:0]    next_step;
  logic          poll_q, pend, byte_mode, hw_reset;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] data_reg;
  logic [DW-1:0] rdata_reg;
  logic          done_f, fail_f, refused_f;
  logic          bypass, suspended, erase_active;
  logic          rb_meta, rb_sync;
  logic          cyc_done;
  logic [DW-1:0] cyc_rdata;

  // ==========================================================
  // sequence table: {last, write, user data, address kind, code}
  function automatic logic [12:0] ent(input logic l, input logic w,
      input logic u, input logic [1:0] k, input logic [7:0] c);
    return {l, w, u, k, c};
  endfunction : ent

  function automatic logic [12:0] step_entry(input fcs_cmd_t c,
                                             input logic [2:0] s);
    logic [12:0] unl;
    unl = (s == 3'h1 || s == 3'h4)
        ? ent(1'h0, 1'h1, 1'h0, `FCS_AK_U2, `FCS_CD_55)
        : ent(1'h0, 1'h1, 1'h0, `FCS_AK_U1, `FCS_CD_AA);
    case (c)
      CMD_READ: step_entry = ent(1'h1, 1'h0, 1'h0, `FCS_AK_USER,
                                 `FCS_CD_ZERO);
      CMD_RESET: step_entry = ent(1'h1, 1'h1, 1'h0, `FCS_AK_ANY,
                                  `FCS_CD_RESET);
      // fourth cycle is a read; sector offset reads give protection
      CMD_AUTOSEL: step_entry = (s == 3'h3)
          ? ent(1'h1, 1'h0, 1'h0, `FCS_AK_USER, `FCS_CD_ZERO)
          : (s == 3'h2)
          ? ent(1'h0, 1'h1, 1'h0, `FCS_AK_U1, `FCS_CD_AUTO) : unl;
      CMD_PROG: step_entry = (s == 3'h3)
          ? ent(1'h1, 1'h1, 1'h1, `FCS_AK_USER, `FCS_CD_ZERO)
          : (s == 3'h2)
          ? ent(1'h0, 1'h1, 1'h0, `FCS_AK_U1, `FCS_CD_PROG) : unl;
      CMD_BYP_ENTER: step_entry = (s == 3'h2)
          ? ent(1'h1, 1'h1, 1'h0, `FCS_AK_U1, `FCS_CD_BYPASS) : unl;
      CMD_BYP_PROG: step_entry = (s == 3'h1)
          ? ent(1'h1, 1'h1, 1'h1, `FCS_AK_USER, `FCS_CD_ZERO)
          : ent(1'h0, 1'h1, 1'h0, `FCS_AK_ANY, `FCS_CD_PROG);
      CMD_BYP_EXIT: step_entry = (s == 3'h1)
          ? ent(1'h1, 1'h1, 1'h0, `FCS_AK_ANY, `FCS_CD_ZERO)
          : ent(1'h0, 1'h1, 1'h0, `FCS_AK_ANY, `FCS_CD_AUTO);
      CMD_CHIP_ERASE: step_entry = (s == 3'h5)
          ? ent(1'h1, 1'h1, 1'h0, `FCS_AK_U1, `FCS_CD_CHIP)
          : (s == 3'h2)
          ? ent(1'h0, 1'h1, 1'h0, `FCS_AK_U1, `FCS_CD_SETUP) : unl;
      CMD_SECT_ERASE: step_entry = (s == 3'h5)
          ? ent(1'h1, 1'h1, 1'h0, `FCS_AK_USER, `FCS_CD_SECT)
          : (s == 3'h2)
          ? ent(1'h0, 1'h1, 1'h0, `FCS_AK_U1, `FCS_CD_SETUP) : unl;
      // extra sector inside the erase window
      CMD_SECT_ADD: step_entry = ent(1'h1, 1'h1, 1'h0, `FCS_AK_USER,
                                     `FCS_CD_SECT);
      CMD_SUSPEND: step_entry = ent(1'h1, 1'h1, 1'h0, `FCS_AK_ANY,
                                    `FCS_CD_SUSP);
      CMD_RESUME: step_entry = ent(1'h1, 1'h1, 1'h0, `FCS_AK_ANY,
                                   `FCS_CD_SECT);
      default: step_entry = ent(1'h1, 1'h0, 1'h0, `FCS_AK_ANY,
                                `FCS_CD_ZERO);
    endcase
  endfunction : step_entry

  // ==========================================================
  // command admission mirrors what the flash will act on
  function automatic logic cmd_allowed(input logic [3:0] c);
    if (bypass)
      return c == CMD_READ || c == CMD_BYP_PROG || c == CMD_BYP_EXIT;
    case (c)
      CMD_BYP_PROG, CMD_BYP_EXIT: return 1'h0;
      CMD_SUSPEND, CMD_SECT_ADD:  return erase_active;
      CMD_RESUME:                 return suspended;
      // suspend still allows read, program, autoselect
      CMD_CHIP_ERASE, CMD_SECT_ERASE, CMD_BYP_ENTER:
        return !suspended && !erase_active;
      CMD_PROG:                   return !erase_active;
      default:                    return c <= CMD_RESUME;
    endcase
  endfunction : cmd_allowed

  // ==========================================================
  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_wr    = psel && penable && pwrite;
  wire hit_ctrl  = paddr == `FCS_REG_CTRL;
  wire hit_addr  = paddr == `FCS_REG_ADDR;
  wire hit_data  = paddr == `FCS_REG_DATA;
  wire hit_cfg   = paddr == `FCS_REG_CFG;
  wire hit_stat  = paddr == `FCS_REG_STAT;
  wire hit_rdata = paddr == `FCS_REG_RDATA;
  wire mapped    = hit_ctrl || hit_addr || hit_data || hit_cfg ||
                   hit_stat || hit_rdata;
  wire ctrl_wr   = apb_wr && hit_ctrl;
  wire accept    = ctrl_wr && state == ST_IDLE && !hw_reset &&
                   cmd_allowed(pwdata[3:0]);
  wire refuse    = ctrl_wr && !accept;
  wire [31:0] stat_word = {24'h0, rb_sync, erase_active, suspended,
                           bypass, refused_f, fail_f, done_f,
                           state != ST_IDLE};
  wire [31:0] rd_mux =
      hit_addr  ? 32'(addr_reg) :
      hit_data  ? 32'(data_reg) :
      hit_cfg   ? {30'h0, hw_reset, byte_mode} :
      hit_stat  ? stat_word :
      hit_rdata ? 32'(rdata_reg) : 32'h0;
  assign pready = 1'h1;

  // ==========================================================
  // cycle requests
  wire [12:0]   ent_w    = step_entry(cmd_q, step);
  wire          ent_last = ent_w[12];
  wire          ent_wr   = ent_w[11];
  wire          ent_ud   = ent_w[10];
  wire [1:0]    ent_ak   = ent_w[9:8];
  wire [AW-1:0] u1_addr  = byte_mode ? AW'(`FCS_U1_BYTE) : AW'(`FCS_U1_WORD);
  wire [AW-1:0] u2_addr  = byte_mode ? AW'(`FCS_U2_BYTE) : AW'(`FCS_U2_WORD);
  wire [AW-1:0] seq_addr = (ent_ak == `FCS_AK_U1) ? u1_addr :
                           (ent_ak == `FCS_AK_U2) ? u2_addr :
                           (ent_ak == `FCS_AK_USER) ? addr_reg : '0;
  // command codes leave the high data byte at zero
  wire [DW-1:0] seq_data = ent_ud ? data_reg : DW'(ent_w[7:0]);
  wire          in_seq    = state == ST_SEQ;
  wire          cyc_start = state != ST_IDLE && !pend;
  wire          cyc_wr    = in_seq ? ent_wr : state == ST_ABORT;
  wire [AW-1:0] cyc_addr  = in_seq ? seq_addr :
                            (state == ST_ABORT) ? '0 : addr_reg;
  wire [DW-1:0] cyc_wdata = in_seq ? seq_data : DW'(`FCS_CD_RESET);
  wire          read_done = cyc_done && !cyc_wr;

  // ==========================================================
  // status polling: program expects true data, erase expects one
  wire is_prog = cmd_q == CMD_PROG || cmd_q == CMD_BYP_PROG;
  wire polled  = is_prog || cmd_q == CMD_CHIP_ERASE ||
                 cmd_q == CMD_SECT_ERASE;
  wire poll_exp   = is_prog ? data_reg[`FCS_DQ_POLL] : 1'h1;
  wire poll_match = cyc_rdata[`FCS_DQ_POLL] == poll_exp;
  wire timeout_hit = cyc_rdata[`FCS_DQ_TIMEOUT];
  wire seq_end = in_seq && cyc_done && ent_last;

  always_comb begin
    next_state = state;
    next_step = step;
    unique case (state)
      ST_IDLE: if (accept) begin
        next_state = ST_SEQ;
        next_step = 3'h0;
      end
      ST_SEQ: if (cyc_done) begin
        if (!ent_last) next_step = step + 3'h1;
        // polling starts right after the final write
        else next_state = (poll_q && polled) ? ST_POLL : ST_IDLE;
      end
      ST_POLL: if (cyc_done) begin
        if (poll_match) next_state = ST_FINAL;
        else if (timeout_hit) next_state = ST_RECHK;
      end
      ST_RECHK: if (cyc_done)
        next_state = poll_match ? ST_FINAL : ST_ABORT;
      ST_FINAL, ST_ABORT: if (cyc_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    rb_meta <= flash_ready_busy_n;
    rb_sync <= rb_meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      {addr_reg, data_reg, byte_mode, hw_reset} <= '0;
      {prdata, pslverr, flash_reset_n} <= '0;
      cmd_q <= CMD_READ;
      state <= ST_IDLE;
      {poll_q, step, pend, rdata_reg} <= '0;
    end else begin
      if (apb_setup) prdata <= rd_mux;
      if (apb_setup) pslverr <= !mapped;
      if (apb_wr && hit_addr) addr_reg <= pwdata[AW-1:0];
      if (apb_wr && hit_data) data_reg <= pwdata[DW-1:0];
      if (apb_wr && hit_cfg) byte_mode <= pwdata[`FCS_CFG_BYTE];
      if (apb_wr && hit_cfg) hw_reset <= pwdata[`FCS_CFG_HWRST];
      flash_reset_n <= !hw_reset;
      if (accept) cmd_q <= fcs_cmd_t'(pwdata[3:0]);
      if (accept) poll_q <= pwdata[`FCS_CTRL_POLL];
      state <= next_state;
      step <= next_step;
      pend <= cyc_start || (pend && !cyc_done);
      if (read_done) rdata_reg <= cyc_rdata;
    end
  end

  // sticky flags: a hardware set wins over the clear of a new command
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      {done_f, fail_f, refused_f} <= '0;
      {bypass, suspended, erase_active} <= '0;
    end else begin
      done_f <= (next_state == ST_IDLE && state != ST_IDLE &&
                 state != ST_ABORT) || (done_f && !accept);
      fail_f <= (state == ST_ABORT && cyc_done) || (fail_f && !accept);
      refused_f <= refuse || (refused_f && !accept);
      if (hw_reset) begin
        {bypass, suspended, erase_active} <= '0;
      end else if (seq_end) begin
        if (cmd_q == CMD_BYP_ENTER) bypass <= 1'h1;
        if (cmd_q == CMD_BYP_EXIT) bypass <= 1'h0;
        if (cmd_q == CMD_SECT_ERASE || cmd_q == CMD_RESUME)
          erase_active <= 1'h1;
        if (cmd_q == CMD_SUSPEND) erase_active <= 1'h0;
        if (cmd_q == CMD_SUSPEND) suspended <= 1'h1;
        if (cmd_q == CMD_RESUME) suspended <= 1'h0;
      end else if (cyc_done && (state == ST_FINAL || state == ST_ABORT) &&
                   cmd_q == CMD_SECT_ERASE) begin
        erase_active <= 1'h0;
      end
    end
  end

  fcs_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .start      (cyc_start),
    .wr         (cyc_wr),
    .addr       (cyc_addr),
    .wdata      (cyc_wdata),
    .dq_in      (flash_dq_in),
    .ce_n       (flash_ce_n),
    .we_n       (flash_we_n),
    .oe_n       (flash_oe_n),
    .flash_addr (flash_addr),
    .dq_out     (flash_dq_out),
    .dq_oe      (flash_dq_oe),
    .rdata      (cyc_rdata),
    .done       (cyc_done)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_timeout_miss;
    state == ST_POLL && cyc_done && !poll_match && timeout_hit;
  endsequence
  sequence s_poll_hit;
    (state == ST_POLL || state == ST_RECHK) && cyc_done && poll_match;
  endsequence

  a_recheck_poll: assert property (s_timeout_miss |=> state == ST_RECHK)
    else $error("timeout bit did not lead to a recheck");
  a_final_read: assert property (
    s_poll_hit |=> state == ST_FINAL ##[1:40] (state == ST_IDLE && done_f))
    else $error("no separate data read after polling hit");
  a_abort_reset: assert property (
    state == ST_RECHK && cyc_done && !poll_match |=> state == ST_ABORT
    ##1 (cyc_wr && cyc_wdata[7:0] == `FCS_CD_RESET))
    else $error("failed operation not followed by reset write");
  a_unlock_first: assert property (
    in_seq && cmd_q == CMD_AUTOSEL && step == 3'h0 && cyc_start |->
    cyc_wr && cyc_wdata[7:0] == `FCS_CD_AA && cyc_addr == u1_addr)
    else $error("autoselect did not open with first unlock");
  a_prog_code: assert property (
    in_seq && cmd_q == CMD_PROG && step == 3'h2 && cyc_start |->
    cyc_wdata[7:0] == `FCS_CD_PROG && cyc_addr == u1_addr)
    else $error("program command code wrong");
  a_erase_sector: assert property (
    in_seq && cmd_q == CMD_SECT_ERASE && step == 3'h5 && cyc_start |->
    cyc_wdata[7:0] == `FCS_CD_SECT && cyc_addr == addr_reg && ent_last)
    else $error("sector erase last cycle wrong");
  a_bypass_only: assert property (
    bypass && ctrl_wr && pwdata[3:0] == CMD_PROG |=>
    refused_f && state == ST_IDLE)
    else $error("plain program accepted in bypass mode");
  a_resume_gate: assert property (
    !suspended && ctrl_wr && pwdata[3:0] == CMD_RESUME |=> state == ST_IDLE)
    else $error("resume accepted while not suspended");
  a_cmd_high_zero: assert property (
    in_seq && cyc_start && ent_wr && !ent_ud |-> cyc_wdata[DW-1:8] == '0)
    else $error("command cycle carried high data bits");
endmodule : fcs_ctrl

// ===== bench/fcs_flash_model.sv
/*
  flash device model: program and bypass program, reset, polling status.
  assumes host strobes on the pins and a pull-up on ready_busy_n.
*/
`timescale 1ns/1ps
module fcs_flash_model (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq,
  output logic             rb_low
);
  logic [15:0] mem [logic [19:0]];
  logic [19:0] la;
  logic [15:0] pd = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic        armed = 1'b0;
  logic        tog = 1'b0;
  int          busy = 0;
  // ==========================================
  // write cycles
  always @(negedge we_n) if (!ce_n) la = addr;
  always @(posedge we_n) if (!ce_n) begin
    if (armed && busy == 0) begin
      mem[la] = dq_in;
      pd = dq_in;
      busy = 3;
      armed = 1'b0;
    end else
      armed = (dq_in[7:0] == 8'ha0);
  end
  // ==========================================
  // read cycles; released bus shows the inverse, no keeper on dq
  always @(negedge oe_n) if (!ce_n) begin
    if (busy > 0) begin
      tog = !tog;
      last = {8'h00, ~pd[7], tog, 6'h00};
      busy = busy - 1;
    end else
      last = mem.exists(addr) ? mem[addr] : 16'hffff;
  end
  assign dq = (!ce_n && !oe_n) ? last : ~last;
  assign rb_low = (busy > 0);
endmodule : fcs_flash_model

// ===== bench/flash_command_decoder_and_status_bench.sv
/*
  bench: apb master, flash model and reference memory, checked per result.
  assumes the register map and poll behaviour of fcs_ctrl.
*/
`timescale 1ns/1ps
`include "fcs_defs.svh"
module flash_command_decoder_and_status_bench;
  logic        ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hd167;
  logic        pready, pslverr, ce_n, we_n, oe_n, dq_oe, rb_low;
  logic [19:0] fa, a;
  logic [15:0] dq_out, mdq, d;
  logic [15:0] ref_mem [logic [19:0]];
  int          n_errors = 0, num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  fcs_ctrl fcs_ctrl_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_reset_n(),
    .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_oe ? dq_out : mdq), .flash_ready_busy_n(!rb_low));
  fcs_flash_model fcs_flash_model_i (.ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .addr(fa), .dq_in(dq_out), .dq(mdq), .rb_low(rb_low));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) n_errors++;
    if (k == 20) finish_test;
    @(posedge ref_clk);
  endtask : apb
  // accepted command: wait for done with busy clear, bounded
  task automatic op(input logic [31:0] c);
    int k;
    apb(1'b1, `FCS_REG_CTRL, c);
    for (k = 0; k < 300; k++) begin
      apb(1'b0, `FCS_REG_STAT, 32'h0);
      if (rd[1:0] === 2'b10) return;
    end
    n_errors++;
    finish_test;
  endtask : op
  task automatic prog(input logic [31:0] c);
    seed = xs(seed);
    a = seed[19:0];
    d = seed[31:16];
    apb(1'b1, `FCS_REG_ADDR, {12'h000, a});
    apb(1'b1, `FCS_REG_DATA, {16'h0000, d});
    op(c);
    ref_mem[a] = d;
    check({29'h0, rd[2:0]}, 32'h2);
    apb(1'b0, `FCS_REG_RDATA, 32'h0);
    check(rd, {16'h0000, ref_mem[a]});
  endtask : prog
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, `FCS_REG_STAT, 32'h0);
    check(rd, 32'h80);
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], pslverr}, 32'h1);
    $display("test reset_map done");
    for (int i = 0; i < 3; i++) begin
      prog(32'h13);
      op(32'h0);
      apb(1'b0, `FCS_REG_RDATA, 32'h0);
      check(rd, {16'h0000, ref_mem[a]});
    end
    $display("test program done");
    op(32'h4);
    check({31'h0, rd[4]}, 32'h1);
    apb(1'b1, `FCS_REG_CTRL, 32'h3);
    apb(1'b0, `FCS_REG_STAT, 32'h0);
    check({31'h0, rd[3]}, 32'h1);
    prog(32'h15);
    op(32'h6);
    check({31'h0, rd[4]}, 32'h0);
    $display("test bypass done");
    apb(1'b1, `FCS_REG_CTRL, 32'ha);
    apb(1'b0, `FCS_REG_STAT, 32'h0);
    check({31'h0, rd[3]}, 32'h1);
    op(32'h1);
    check({31'h0, rd[3]}, 32'h0);
    apb(1'b1, `FCS_REG_CTRL, 32'hb);
    apb(1'b0, `FCS_REG_STAT, 32'h0);
    check({31'h0, rd[3]}, 32'h1);
    op(32'h2);
    check({29'h0, rd[2:0]}, 32'h2);
    op(32'h8);
    check({31'h0, rd[6]}, 32'h1);
    op(32'ha);
    check({30'h0, rd[6:5]}, 32'h1);
    op(32'hb);
    check({30'h0, rd[6:5]}, 32'h2);
    $display("test suspend_resume done");
    finish_test;
  end
endmodule : flash_command_decoder_and_status_bench
